/* File: inc/rcs_pkg.sv */
// package for the reset and clock select block
package rcs_pkg;
    // register byte offsets
    localparam logic [7:0] RCS_OFF_CTRL = 8'h00; // mask, sw reset, clock
    localparam logic [7:0] RCS_OFF_WDOG = 8'h04; // watchdog lock
    localparam logic [7:0] RCS_OFF_STAT = 8'h08; // cause and clock status
    // control register field positions
    localparam int RCS_CTRL_WDOG_EN = 0;
    localparam int RCS_CTRL_MCD_EN = 1;
    localparam int RCS_CTRL_CMP_EN = 2;
    localparam int RCS_CTRL_SW_EN = 3;
    localparam int RCS_CTRL_CNV_EN = 4;
    localparam int RCS_CTRL_CLK_EXT = 8;
    localparam int RCS_CTRL_SW_RST = 16;
    // watchdog register field positions
    localparam int RCS_WDOG_LOCK = 0;
    // reset values
    localparam logic [4:0] RCS_MASK_RST = 5'h1f; // sources enabled
    localparam logic RCS_CLK_RST = 1'b0; // internal oscillator
    // length of the reset pulse driven out, in cycles
    localparam logic [3:0] RCS_RST_HOLD = 4'h8;
    // axi response codes
    localparam logic [1:0] RCS_RESP_OK = 2'b00;
    localparam logic [1:0] RCS_RESP_SLVERR = 2'b10;
    // reset cause record
    typedef struct packed {
        logic pin;
        logic cnv;
        logic sw;
        logic cmp;
        logic mcd;
        logic wdog;
        logic supply;
    } rcs_cause_t;
endpackage : rcs_pkg

/* File: rtl/rcs_top.sv */
// reset source collection and system clock selection with axi4-lite regs
// Function
// RULE1 - any of seven sources resets device
// RULE2 - reset pin bidirectional, drives internal reset out
// RULE3 - software masks all but supply and pin
// RULE4 - supply monitor gated by enable pin only
// RULE5 - software may lock watchdog enabled
// RULE6 - internal oscillator selected after any reset
// RULE7 - software switches clock source while running
// RULE8 - locked watchdog ignores later disable writes
`timescale 1ns/100ps
`default_nettype none
module rcs_top
    import rcs_pkg::*;
(
    input wire logic CLK_SYS_I,
    input wire logic RST_I,
    // reset source inputs, from other clock domains or pins
    input wire logic SUPPLY_LOW_I,
    input wire logic SUPPLY_MONITOR_ENABLE_PIN_I,
    input wire logic WDOG_TIMEOUT_I,
    input wire logic MISSING_CLK_I,
    input wire logic CMP_DETECT_I,
    input wire logic CONVERSION_START_PIN_I,
    // bidirectional reset pin, active low
    input wire logic RST_PIN_N_I,
    output logic RST_PIN_N_O,
    output logic RST_PIN_OE_O,
    // system reset and clock select
    output logic SYS_RST_O,
    output logic CLK_SEL_EXT_O,
    output logic WDOG_EN_O,
    // axi4-lite slave
    input wire logic [7:0] AWADDR_I,
    input wire logic AWVALID_I,
    output logic AWREADY_O,
    input wire logic [31:0] WDATA_I,
    input wire logic [3:0] WSTRB_I,
    input wire logic WVALID_I,
    output logic WREADY_O,
    output logic [1:0] BRESP_O,
    output logic BVALID_O,
    input wire logic BREADY_I,
    input wire logic [7:0] ARADDR_I,
    input wire logic ARVALID_I,
    output logic ARREADY_O,
    output logic [31:0] RDATA_O,
    output logic [1:0] RRESP_O,
    output logic RVALID_O,
    input wire logic RREADY_I
);
    // two-stage synchronisers for the six outside inputs
    localparam int NSYNC = 6;
    logic [NSYNC-1:0] sync_in;
    logic [NSYNC-1:0] sync1_reg;
    logic [NSYNC-1:0] sync2_reg;
    assign sync_in = {~RST_PIN_N_I, CONVERSION_START_PIN_I, CMP_DETECT_I,
                      MISSING_CLK_I, WDOG_TIMEOUT_I, SUPPLY_LOW_I};
    logic mon_en1_reg; // monitor enable pin, stage one
    logic mon_en2_reg; // monitor enable pin, stage two

    // synchroniser chain per input
    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi++) begin : g_sync
            always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
                if (RST_I) begin
                    sync1_reg[gi] <= 1'b0;
                    sync2_reg[gi] <= 1'b0;
                end else begin
                    sync1_reg[gi] <= sync_in[gi];
                    sync2_reg[gi] <= sync1_reg[gi];
                end
            end
        end
    endgenerate

    // monitor enable pin synchroniser; enabled while in reset
    always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            mon_en1_reg <= 1'b1;
            mon_en2_reg <= 1'b1;
        end else begin
            mon_en1_reg <= SUPPLY_MONITOR_ENABLE_PIN_I;
            mon_en2_reg <= mon_en1_reg;
        end
    end

    // software state
    logic [4:0] mask_reg; // enables: wdog, mcd, cmp, sw, cnv
    logic [4:0] mask_next;
    logic clk_ext_reg; // clock select, one is external
    logic clk_ext_next;
    logic wdog_lock_reg; // watchdog locked enabled
    logic wdog_lock_next;
    logic sw_rst_reg; // one-cycle software reset request
    logic sw_rst_next;
    rcs_cause_t cause_reg; // last reset cause, sticky
    rcs_cause_t cause_next;
    rcs_cause_t hit; // sources asserting now, after gating
    logic any_hit;
    logic [3:0] hold_reg; // reset stretch counter
    logic [3:0] hold_next;
    logic sys_rst_reg; // internal system reset
    logic pin_drive_reg; // drive reset pin low
    logic [1:0] drive_seen_reg; // own drive, delayed by the sync depth
    logic wdog_en_eff; // watchdog effectively enabled

    // source gating
    assign wdog_en_eff = mask_reg[0] | wdog_lock_reg; // RULE5
    assign hit.supply = sync2_reg[0] & mon_en2_reg; // RULE4
    assign hit.wdog = sync2_reg[1] & wdog_en_eff; // RULE3
    assign hit.mcd = sync2_reg[2] & mask_reg[1]; // RULE3
    assign hit.cmp = sync2_reg[3] & mask_reg[2]; // RULE3
    assign hit.sw = sw_rst_reg & mask_reg[3]; // RULE3
    assign hit.cnv = sync2_reg[4] & mask_reg[4]; // RULE3
    // pin input is never masked; own drive and its two-cycle echo through
    // the synchroniser are excluded so the drive cannot retrigger itself
    assign hit.pin = sync2_reg[5] & ~pin_drive_reg & ~(|drive_seen_reg); // RULE3
    assign any_hit = |hit; // RULE1

    // axi write path: address and data latched in either order
    logic aw_full_reg;
    logic [7:0] aw_addr_reg;
    logic w_full_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    logic awready_reg; // address latch free
    logic wready_reg; // data latch free
    logic wr_fire;
    logic wr_ctrl;
    logic wr_wdog;
    logic wr_ok;
    assign wr_fire = aw_full_reg & w_full_reg & ~bvalid_reg;
    assign wr_ctrl = wr_fire & (aw_addr_reg[7:2] == RCS_OFF_CTRL[7:2]);
    assign wr_wdog = wr_fire & (aw_addr_reg[7:2] == RCS_OFF_WDOG[7:2]);
    assign wr_ok = (aw_addr_reg[7:2] == RCS_OFF_CTRL[7:2]) |
                   (aw_addr_reg[7:2] == RCS_OFF_WDOG[7:2]) |
                   (aw_addr_reg[7:2] == RCS_OFF_STAT[7:2]);

    // next values of software state
    always_comb begin
        mask_next = mask_reg;
        clk_ext_next = clk_ext_reg;
        wdog_lock_next = wdog_lock_reg;
        sw_rst_next = 1'b0;
        if (wr_ctrl && w_strb_reg[0]) begin
            // watchdog bit change; lock keeps it set
            mask_next = w_data_reg[4:0];
            mask_next[0] = w_data_reg[RCS_CTRL_WDOG_EN] | wdog_lock_reg; // RULE8
        end
        if (wr_ctrl && w_strb_reg[1]) begin
            clk_ext_next = w_data_reg[RCS_CTRL_CLK_EXT]; // RULE7
        end
        if (wr_ctrl && w_strb_reg[2]) begin
            sw_rst_next = w_data_reg[RCS_CTRL_SW_RST];
        end
        if (wr_wdog && w_strb_reg[0] && w_data_reg[RCS_WDOG_LOCK]) begin
            wdog_lock_next = 1'b1; // RULE5
            mask_next[0] = 1'b1; // RULE5
        end
    end

    // software state registers, cleared by any system reset
    always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            mask_reg <= RCS_MASK_RST;
            clk_ext_reg <= RCS_CLK_RST;
            wdog_lock_reg <= 1'b0;
            sw_rst_reg <= 1'b0;
        end else if (sys_rst_reg) begin
            mask_reg <= RCS_MASK_RST;
            clk_ext_reg <= RCS_CLK_RST; // RULE6
            wdog_lock_reg <= 1'b0; // RULE8
            sw_rst_reg <= 1'b0;
        end else begin
            mask_reg <= mask_next;
            clk_ext_reg <= clk_ext_next;
            wdog_lock_reg <= wdog_lock_next;
            sw_rst_reg <= sw_rst_next;
        end
    end

    // reset stretching and cause capture
    always_comb begin
        hold_next = hold_reg;
        cause_next = cause_reg;
        if (any_hit) begin
            hold_next = RCS_RST_HOLD; // RULE1
            cause_next = hit;
        end else if (hold_reg != 4'h0) begin
            hold_next = hold_reg - 4'h1;
        end
    end

    // system reset and pin drive; power-on reset is driven out too
    always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            hold_reg <= RCS_RST_HOLD;
            cause_reg <= '0;
            sys_rst_reg <= 1'b1;
            pin_drive_reg <= 1'b1;
            drive_seen_reg <= 2'h3;
        end else begin
            hold_reg <= hold_next;
            cause_reg <= cause_next;
            sys_rst_reg <= any_hit | (hold_reg != 4'h0); // RULE1
            pin_drive_reg <= (hold_next != 4'h0) & ~hit.pin; // RULE2
            // remember the drive until the pin level has passed both stages
            drive_seen_reg <= {drive_seen_reg[0], pin_drive_reg};
        end
    end

    // axi write channel handshakes
    always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            aw_full_reg <= 1'b0;
            awready_reg <= 1'b1;
            aw_addr_reg <= 8'h00;
            w_full_reg <= 1'b0;
            wready_reg <= 1'b1;
            w_data_reg <= 32'h0000_0000;
            w_strb_reg <= 4'h0;
            bvalid_reg <= 1'b0;
            bresp_reg <= RCS_RESP_OK;
        end else begin
            if (AWVALID_I && !aw_full_reg) begin
                aw_full_reg <= 1'b1;
                awready_reg <= 1'b0;
                aw_addr_reg <= AWADDR_I;
            end
            if (WVALID_I && !w_full_reg) begin
                w_full_reg <= 1'b1;
                wready_reg <= 1'b0;
                w_data_reg <= WDATA_I;
                w_strb_reg <= WSTRB_I;
            end
            if (wr_fire) begin
                // both halves present: answer and free the latches
                aw_full_reg <= 1'b0;
                w_full_reg <= 1'b0;
                awready_reg <= 1'b1;
                wready_reg <= 1'b1;
                bvalid_reg <= 1'b1;
                bresp_reg <= wr_ok ? RCS_RESP_OK : RCS_RESP_SLVERR;
            end else if (bvalid_reg && BREADY_I) begin
                bvalid_reg <= 1'b0;
            end
        end
    end

    // axi read path, status shows cause, clock and monitor enable
    logic rvalid_reg;
    logic arready_reg; // read address accepted when high
    logic [31:0] rdata_reg;
    logic [1:0] rresp_reg;
    logic [31:0] ctrl_view;
    logic [31:0] wdog_view;
    logic [31:0] stat_view;
    logic [31:0] rd_mux;
    logic rd_ok;
    assign ctrl_view = {23'h00_0000, clk_ext_reg, 3'h0, mask_reg[4:1],
                        wdog_en_eff};
    assign wdog_view = {31'h0000_0000, wdog_lock_reg};
    assign stat_view = {22'h00_0000, mon_en2_reg, clk_ext_reg, 1'b0,
                        cause_reg};
    assign rd_ok = (ARADDR_I[7:2] == RCS_OFF_CTRL[7:2]) |
                   (ARADDR_I[7:2] == RCS_OFF_WDOG[7:2]) |
                   (ARADDR_I[7:2] == RCS_OFF_STAT[7:2]);
    assign rd_mux = (ARADDR_I[7:2] == RCS_OFF_CTRL[7:2]) ? ctrl_view :
                    (ARADDR_I[7:2] == RCS_OFF_WDOG[7:2]) ? wdog_view :
                    (ARADDR_I[7:2] == RCS_OFF_STAT[7:2]) ? stat_view :
                    32'h0000_0000;

    // read channel: take address when idle, hold data until rready
    always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            rvalid_reg <= 1'b0;
            arready_reg <= 1'b1;
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= RCS_RESP_OK;
        end else if (!rvalid_reg && ARVALID_I) begin
            rvalid_reg <= 1'b1;
            arready_reg <= 1'b0;
            rdata_reg <= rd_mux;
            rresp_reg <= rd_ok ? RCS_RESP_OK : RCS_RESP_SLVERR;
        end else if (rvalid_reg && RREADY_I) begin
            rvalid_reg <= 1'b0;
            arready_reg <= 1'b1;
        end
    end

    // outputs, all from flip-flops except the constant RST_PIN_N_O
    assign AWREADY_O = awready_reg;
    assign WREADY_O = wready_reg;
    assign BVALID_O = bvalid_reg;
    assign BRESP_O = bresp_reg;
    assign ARREADY_O = arready_reg;
    assign RVALID_O = rvalid_reg;
    assign RDATA_O = rdata_reg;
    assign RRESP_O = rresp_reg;
    assign SYS_RST_O = sys_rst_reg;
    assign RST_PIN_N_O = 1'b0;
    assign RST_PIN_OE_O = pin_drive_reg; // RULE2
    assign CLK_SEL_EXT_O = clk_ext_reg; // RULE6
    assign WDOG_EN_O = mask_reg[0]; // RULE5
endmodule : rcs_top
`default_nettype wire

/* File: verification/rcs_assertions.sv */
// assertion checker for the reset and clock select block
`timescale 1ns/100ps
`default_nettype none
module rcs_chk
    import rcs_pkg::*;
(
    input wire logic CLK_SYS_I, RST_I, SUPPLY_LOW_I,
    input wire logic SUPPLY_MONITOR_ENABLE_PIN_I, CMP_DETECT_I,
    input wire logic RST_PIN_N_I, RST_PIN_N_O, RST_PIN_OE_O, SYS_RST_O,
    input wire logic CLK_SEL_EXT_O, WDOG_EN_O, AWVALID_I, AWREADY_O,
    input wire logic WVALID_I, ARVALID_I, ARREADY_O, RVALID_O, RREADY_I,
    input wire logic [7:0] AWADDR_I, ARADDR_I,
    input wire logic [31:0] WDATA_I, RDATA_O,
    input wire logic [1:0] RRESP_O
);
    logic [2:0] lk; // lock write seen, delayed until the register lands
    wire logic lk_set; // lock write taken outside system reset
    wire logic ar_bad; // read of an unmapped word taken
    assign lk_set = AWVALID_I && AWREADY_O && WVALID_I && WDATA_I[0]
        && AWADDR_I == RCS_OFF_WDOG && !SYS_RST_O;
    assign ar_bad = ARVALID_I && ARREADY_O && !(ARADDR_I[7:2] inside
        {RCS_OFF_CTRL[7:2], RCS_OFF_WDOG[7:2], RCS_OFF_STAT[7:2]});
    // any system reset forgets the lock
    always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) lk <= 3'h0;
        else lk <= SYS_RST_O ? 3'h0 : {lk[1:0], lk[0] | lk_set};
    end
    default clocking cb @(posedge CLK_SYS_I); endclocking
    default disable iff (RST_I);
    property p_supply;
        (SUPPLY_LOW_I && SUPPLY_MONITOR_ENABLE_PIN_I)[*3]
            |-> ##[0:3] SYS_RST_O;
    endproperty
    a_supply: assert property (p_supply)
        else $error("supply trip gave no reset");
    property p_pin;
        (!RST_PIN_N_I && !RST_PIN_OE_O)[*3] |-> ##[0:3] SYS_RST_O;
    endproperty
    a_pin: assert property (p_pin)
        else $error("external reset pin gave no reset");
    property p_drive;
        RST_PIN_OE_O |-> !RST_PIN_N_O && (SYS_RST_O || $past(SYS_RST_O));
    endproperty
    a_drive: assert property (p_drive)
        else $error("reset pin driven outside a system reset");
    property p_clk_int;
        SYS_RST_O [*2] |-> !CLK_SEL_EXT_O;
    endproperty
    a_clk_int: assert property (p_clk_int)
        else $error("external clock kept during reset");
    property p_stretch;
        $fell(CMP_DETECT_I) && SYS_RST_O |-> SYS_RST_O [*8];
    endproperty
    a_stretch: assert property (p_stretch)
        else $error("reset ended early after comparator release");
    property p_rd_err;
        ar_bad |=> RVALID_O && RRESP_O == RCS_RESP_SLVERR && RDATA_O == 0;
    endproperty
    a_rd_err: assert property (p_rd_err)
        else $error("unmapped read not refused");
    property p_r_hold;
        RVALID_O && !RREADY_I |=> RVALID_O && $stable(RDATA_O);
    endproperty
    a_r_hold: assert property (p_r_hold)
        else $error("read answer dropped before taken");
    property p_lock;
        lk[2] && !SYS_RST_O |-> WDOG_EN_O;
    endproperty
    a_lock: assert property (p_lock)
        else $error("locked watchdog turned off");
    c_lock: cover property (lk[2] && !SYS_RST_O);
    c_ext: cover property (CLK_SEL_EXT_O);
    c_err: cover property (ar_bad);
    c_stall: cover property (RVALID_O && !RREADY_I);
endmodule : rcs_chk
bind rcs_top rcs_chk u_chk (.*);
`default_nettype wire

/* File: verification/rcs_partner.sv */
// external reset circuit on the pulled-up open-drain reset wire
`timescale 1ns/100ps
`default_nettype none
module rcs_partner (
    input wire logic pull_i,
    input wire logic oe_i,
    input wire logic drv_i,
    output wire logic pin_n_o
);
    // wired-and of both pullers, pull-up when nobody pulls
    assign pin_n_o = !(pull_i || (oe_i && !drv_i));
endmodule : rcs_partner
`default_nettype wire

/* File: verification/rcs_top_bench.sv */
// self-checking bench for the reset and clock select block
`timescale 1ns/100ps
`default_nettype none
module rcs_top_bench;
    import rcs_pkg::*;
    logic clk = 1'b0, rst = 1'b1, mon = 1'b1, awv = 1'b0, wv = 1'b0;
    logic bre = 1'b0, arv = 1'b0, rre = 1'b0, c, s;
    logic [7:0] src = 8'h00, awa = 8'h00, ara = 8'h00;
    logic [31:0] wd = 32'h0000_0000, d;
    logic [1:0] r;
    logic [4:0] m;
    wire logic pin_n, pin_o, oe, srst, cext, wen, awr, wrd, bv, arr, rv;
    wire logic [1:0] br, rr;
    wire logic [31:0] rd;
    int errors = 0, n_checks = 0, n, k;
    rcs_partner u_p (.pull_i(src[6]), .oe_i(oe), .drv_i(pin_o),
        .pin_n_o(pin_n));
    rcs_top dut (.CLK_SYS_I(clk), .RST_I(rst), .SUPPLY_LOW_I(src[5]),
        .SUPPLY_MONITOR_ENABLE_PIN_I(mon), .WDOG_TIMEOUT_I(src[0]),
        .MISSING_CLK_I(src[1]), .CMP_DETECT_I(src[2]),
        .CONVERSION_START_PIN_I(src[4]), .RST_PIN_N_I(pin_n),
        .RST_PIN_N_O(pin_o), .RST_PIN_OE_O(oe), .SYS_RST_O(srst),
        .CLK_SEL_EXT_O(cext), .WDOG_EN_O(wen), .AWADDR_I(awa),
        .AWVALID_I(awv), .AWREADY_O(awr), .WDATA_I(wd), .WSTRB_I(4'hf),
        .WVALID_I(wv), .WREADY_O(wrd), .BRESP_O(br), .BVALID_O(bv),
        .BREADY_I(bre), .ARADDR_I(ara), .ARVALID_I(arv), .ARREADY_O(arr),
        .RDATA_O(rd), .RRESP_O(rr), .RVALID_O(rv), .RREADY_I(rre));
    initial forever #10 clk = ~clk;
    // source k: 0..4 maskable, 5 supply, 6 pin, 7 supply with monitor off
    function automatic logic [31:0] cause(int k);
        return 32'h1 << (k == 5 ? 0 : k == 6 ? 6 : k + 1);
    endfunction : cause
    function automatic logic hit(int k, logic [4:0] m);
        return k < 5 ? m[k] : k < 7;
    endfunction : hit
    task automatic end_of_test();
        if (errors == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : end_of_test
    task automatic stop();
        errors++;
        end_of_test();
    endtask : stop
    task automatic chk(input string nm, input logic [31:0] e, g);
        n_checks++;
        if (g !== e) begin
            errors++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // bounded wait for the system reset to reach a level
    task automatic wt(input logic v, input int lim);
        s = 1'b0;
        for (int i = 0; i < lim && !s; i++) begin
            @(posedge clk);
            s = srst === v;
        end
    endtask : wt
    // write: address and data together, response into r
    task automatic wrw(input logic [7:0] a, input logic [31:0] v);
        int i;
        @(posedge clk);
        {awa, wd, awv, wv, bre} <= {a, v, 3'b111};
        for (i = 0; i < 40; i++) begin
            @(posedge clk);
            if (awr) awv <= 1'b0;
            if (wrd) wv <= 1'b0;
            if (bv) break;
        end
        r = br;
        bre <= 1'b0;
        if (i == 40) stop();
    endtask : wrw
    // read with one stall cycle on rready, data into d
    task automatic rdw(input logic [7:0] a);
        int i;
        @(posedge clk);
        {ara, arv} <= {a, 1'b1};
        for (i = 0; i < 40; i++) begin
            @(posedge clk);
            if (arr) arv <= 1'b0;
            if (rv && rre) break;
            rre <= i > 0;
        end
        {d, r} = {rd, rr};
        rre <= 1'b0;
        if (i == 40) stop();
    endtask : rdw
    initial begin
        void'($urandom(11989));
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        wt(1'b0, 40);
        if (!s) stop();
        rdw(RCS_OFF_CTRL);
        chk("ctrl", {27'h0, RCS_MASK_RST}, d);
        chk("clk_sel", RCS_CLK_RST, cext);
        rdw(8'h0c);
        chk("rresp", RCS_RESP_SLVERR, {d[0], r});
        wrw(8'h10, 32'h0000_0000);
        chk("bresp", RCS_RESP_SLVERR, r);
        // all enabled, all masked, then random masks and clock choice
        for (n = 0; n < 32; n++) begin
            k = n % 8;
            m = n < 8 ? 5'h1f : n < 16 ? 5'h00 : 5'($urandom);
            c = 1'($urandom);
            wrw(RCS_OFF_CTRL, {23'h0, c, 3'h0, m});
            chk("clk_sel", c, cext);
            chk("wdog_en", m[0], wen);
            if (k == 3) wrw(RCS_OFF_CTRL, {23'h80, c, 3'h0, m});
            mon <= k != 7;
            src[k == 7 ? 5 : k] <= k != 3;
            repeat (4) @(posedge clk);
            src <= 8'h00;
            wt(1'b1, 14);
            chk("sys_rst", hit(k, m), s);
            if (s) begin
                wt(1'b0, 40);
                if (!s) stop();
                chk("clk_int", RCS_CLK_RST, cext);
                rdw(RCS_OFF_STAT);
                chk("cause", cause(k), d & 32'h7f);
            end
            mon <= 1'b1;
        end
        // lock the watchdog, try to turn it off, then reset by the pin
        wrw(RCS_OFF_WDOG, 32'h0000_0001);
        rdw(RCS_OFF_WDOG);
        chk("lock", 32'h1, d & 32'h1);
        wrw(RCS_OFF_CTRL, 32'h0000_001e);
        chk("wdog_en", 1'b1, wen);
        src[6] <= 1'b1;
        repeat (4) @(posedge clk);
        src[6] <= 1'b0;
        wt(1'b1, 14);
        chk("sys_rst", 1'b1, s);
        wt(1'b0, 40);
        if (!s) stop();
        rdw(RCS_OFF_WDOG);
        chk("lock", 32'h0, d & 32'h1);
        wrw(RCS_OFF_CTRL, 32'h0000_001e);
        chk("wdog_en", 1'b0, wen);
        end_of_test();
    end
endmodule : rcs_top_bench
`default_nettype wire
